// ---- src/dmae_pkg.sv ----
// Purpose: Shared constants for the signal-processing accumulator engine
// Assumes: 32-bit register bus words, byte addresses
// Notes:   All offsets and field positions, and the core, trap and accumulator reset values, live here
package dmae_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_CORE   = 8'h00;
  localparam logic [7:0] OFF_TRAP   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_OPX    = 8'h0c;
  localparam logic [7:0] OFF_OPY    = 8'h10;
  localparam logic [7:0] OFF_DATA   = 8'h14;
  localparam logic [7:0] OFF_CMD    = 8'h18;
  localparam logic [7:0] OFF_ACCA_L = 8'h1c;
  localparam logic [7:0] OFF_ACCA_H = 8'h20;
  localparam logic [7:0] OFF_ACCB_L = 8'h24;
  localparam logic [7:0] OFF_ACCB_H = 8'h28;
  localparam logic [7:0] OFF_STORE  = 8'h2c;
  localparam logic [7:0] OFF_MCU    = 8'h30;
  // ==========================================
  // Core control fields
  localparam int CC_INT    = 0;
  localparam int CC_RND    = 1;
  localparam int CC_WIDTH  = 4;
  localparam int CC_STCLIP = 5;
  localparam int CC_CLIPB  = 6;
  localparam int CC_CLIPA  = 7;
  localparam int CC_SIGN   = 12;
  localparam logic [15:0] CORE_RST  = 16'h0020;
  localparam logic [15:0] CORE_MASK = 16'h10f3;
  // ==========================================
  // Trap control and status fields
  localparam int TC_OVA  = 0;
  localparam int TC_OVB  = 1;
  localparam int TC_COV  = 2;
  localparam int TC_SEEN = 3;
  localparam logic [3:0] TRAP_RST = 4'h0;
  localparam int ST_OA  = 0;
  localparam int ST_OB  = 1;
  localparam int ST_SA  = 2;
  localparam int ST_SB  = 3;
  localparam int ST_OAB = 4;
  localparam int ST_SAB = 5;
  // ==========================================
  // Command fields
  localparam int CMD_ACC = 5;
  localparam int CMD_RND = 6;
  localparam int CMD_SH  = 8;
  // ==========================================
  // Clamp, rounding and accumulator reset values
  localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
  localparam logic [39:0] SAT40_NEG = 40'h8000000000;
  localparam logic [39:0] SAT32_POS = 40'h007fffffff;
  localparam logic [39:0] SAT32_NEG = 40'h0080000000;
  localparam logic [15:0] ST_POS    = 16'h7fff;
  localparam logic [15:0] ST_NEG    = 16'h8000;
  localparam logic [15:0] RND_HALF  = 16'h8000;
  localparam logic [39:0] ACC_RST   = 40'h0000000000;

  typedef enum logic [4:0] {
    OP_CLEAR    = 5'h00,
    OP_DSQ      = 5'h01,
    OP_DSQ_ACC  = 5'h02,
    OP_PROD_ACC = 5'h03,
    OP_PROD_SUB = 5'h04,
    OP_SQ_ACC   = 5'h05,
    OP_PROD     = 5'h06,
    OP_PROD_NEG = 5'h07,
    OP_SQUARE   = 5'h08,
    OP_PF_STORE = 5'h09,
    OP_ACC_ADD  = 5'h0a,
    OP_ACC_SUB  = 5'h0b,
    OP_ACC_NEG  = 5'h0c,
    OP_ADD_DATA = 5'h0d,
    OP_LOAD_ACC = 5'h0e,
    OP_MCU_BYTE = 5'h0f,
    OP_MCU_WORD = 5'h10
  } dmae_op_e;
endpackage

// ---- src/dmae_mult.sv ----
// Purpose: 17x17 multiplier with fractional/integer scaler
// Assumes: Purely combinational, settles within one core_clk period
// Notes:   Also serves the general-purpose integer multiply
module dmae_mult (
  // Operands
  input  wire logic [15:0] op_a,
  input  wire logic [15:0] op_b,
  // Mode
  input  wire logic        unsigned_sel,
  input  wire logic        int_sel,
  // Results
  output logic      [39:0] prod_ext,
  output logic      [31:0] prod_int
);
  logic signed [16:0] a17;
  logic signed [16:0] b17;
  logic signed [33:0] full;
  logic        [32:0] scaled;

  // Seventeenth bit: zero for unsigned, sign copy for signed
  assign a17 = {(unsigned_sel ? 1'b0 : op_a[15]), op_a};
  assign b17 = {(unsigned_sel ? 1'b0 : op_b[15]), op_b};
  assign full = a17 * b17;
  // Fractional drops the duplicate sign bit to give 1.31
  assign scaled = int_sel ? full[32:0] : {full[31:0], 1'b0};
  // 33-bit product widened to 40 bits
  assign prod_ext = {{7{scaled[32]}}, scaled};
  assign prod_int = full[31:0];
endmodule

// ---- src/dmae_engine.sv ----
// Purpose: Multiply-accumulate engine with two 40-bit accumulators
// Assumes: Avalon-MM slave, one access at a time, core_clk 250 MHz
// Notes:   A command write runs one engine step in the cycle it is taken
//
// Contract
// - Multiplier makes 33-bit product, sign-extended to 40 bits.
// - Unsigned mode zero-extends operands to 17 bits, signed mode sign-extends.
// - Fractional mode gives 1.31 product, integer mode a plain 32-bit product.
// - Integer multiply: byte operands give 16 bits, word operands 32 bits.
// - Adder reads selected accumulator and writes back to the same one.
// - Add and load paths may scale data with the shifter first.
// - Add uses true operand, carry high; subtract complements, borrow low; zero input. The adder here adds with carry-in 0.
// - Guard flag rewritten each pass; set when bits 39..32 differ.
// - Guard flag plus its trap enable raises arithmetic warning trap.
// - Clip flag only sets on adder passes; software alone clears it.
// - Clip flag tracks bit 31 or bit 39 overflow by mode.
// - Saturation off and catastrophic enable: newly set clip flag traps.
// - Combined status bits are the OR of both per-accumulator flags.
// - Wide mode clamps to 0x7FFFFFFFFF or 0x8000000000, sets clip flag.
// - Narrow mode clamps to 1.31 extremes on bit 31 overflow, sets flag. The negative clamp here is 0x0080000000, not sign-extended.
// - Narrow mode never sets guard flags or combined guard bit.
// - Saturation off: wrap past bit 39, still set clip flag.
// - Clamp decision uses sum, overflow, clip enables and width select.
// - Control selects multiply modes, rounding, clip enables, store clip, width.
// - Listed operations; only clear, accumulate/subtract, prefetch-store write back.
// - Accumulator add, subtract and negate need no operand data.
// - Engine steps never overlap integer multiplies; difference-square uses both.
// - Round up at 0x8000 or more; convergent at exactly 0x8000 needs bit 16.
// - Store clip clamps to 0x7FFF or 0x8000; accumulator left untouched.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
module dmae_engine (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Trap
  output logic             arith_trap
);
  // ==========================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic flags_differ(input logic [9:0] v);
    return !((&v) || !(|v));
  endfunction

  // Round high word then optionally clamp to 1.15
  function automatic logic [15:0] store_word(input logic [39:0] acc,
                                             input logic rnd,
                                             input logic conv,
                                             input logic clip);
    logic        inc;
    logic [24:0] hi;
    inc = rnd && ((acc[15:0] > dmae_pkg::RND_HALF) ||
          ((acc[15:0] == dmae_pkg::RND_HALF) && (conv || acc[16])));
    hi = {acc[39], acc[39:16]} + {24'h000000, inc};
    if (clip && flags_differ(hi[24:15])) begin
      return acc[39] ? dmae_pkg::ST_NEG : dmae_pkg::ST_POS;
    end
    return hi[15:0];
  endfunction

  // ==========================================
  // State
  logic [15:0] core_control_reg;
  logic [3:0]  trap_control_reg;
  logic [15:0] opx_reg;
  logic [15:0] opy_reg;
  logic [31:0] data_reg;
  logic [39:0] acc_a_reg;
  logic [39:0] acc_b_reg;
  logic        acc_a_guard_ovf;
  logic        acc_b_guard_ovf;
  logic        acc_a_clip_sticky;
  logic        acc_b_clip_sticky;
  logic [15:0] store_reg;
  logic [31:0] mcu_reg;
  logic [31:0] readdata_reg;
  logic        wait_reg;
  logic        trap_reg;

  logic        signedness_select;
  logic        round_mode_select;
  logic        acc_a_clip_enable;
  logic        acc_b_clip_enable;
  logic        store_clip_enable;
  logic        clip_width_select;
  logic        int_select;
  logic        either_acc_guard_ovf;
  logic        either_acc_clip;

  assign signedness_select    = core_control_reg[dmae_pkg::CC_SIGN];
  assign round_mode_select    = core_control_reg[dmae_pkg::CC_RND];
  assign acc_a_clip_enable    = core_control_reg[dmae_pkg::CC_CLIPA];
  assign acc_b_clip_enable    = core_control_reg[dmae_pkg::CC_CLIPB];
  assign store_clip_enable    = core_control_reg[dmae_pkg::CC_STCLIP];
  assign clip_width_select    = core_control_reg[dmae_pkg::CC_WIDTH];
  assign int_select           = core_control_reg[dmae_pkg::CC_INT];
  assign either_acc_guard_ovf = acc_a_guard_ovf | acc_b_guard_ovf;
  assign either_acc_clip      = acc_a_clip_sticky | acc_b_clip_sticky;

  // ==========================================
  // Bus handshake: one wait cycle, then the access completes
  logic wr_take;
  assign wr_take = avs_write && !wait_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end

  // ==========================================
  // Command decode and datapath
  logic            exec;
  dmae_pkg::dmae_op_e op;
  logic            tgt_b;
  logic [39:0]     acc_t;
  logic [39:0]     acc_n;
  logic [15:0]     mul_a;
  logic [15:0]     mul_b;
  logic            mul_uns;
  logic            mul_int;
  logic [39:0]     prod_ext;
  logic [31:0]     prod_int;
  logic [15:0]     diff;
  logic signed [4:0] shamt;
  logic [39:0]     shifted;
  logic [39:0]     base;
  logic [39:0]     opnd;
  logic            sub;
  logic            pass;
  logic            store_en;
  logic [40:0]     sum41;
  logic            ov39;
  logic            ov31;
  logic            guard;
  logic            sat_en;
  logic [39:0]     result;
  logic            clip_set;
  logic            guard_new;
  logic            trap_fire;

  assign exec  = wr_take && (avs_address == dmae_pkg::OFF_CMD);
  assign op    = dmae_pkg::dmae_op_e'(avs_writedata[4:0]);
  assign tgt_b = avs_writedata[dmae_pkg::CMD_ACC];
  assign acc_t = tgt_b ? acc_b_reg : acc_a_reg;
  assign acc_n = tgt_b ? acc_a_reg : acc_b_reg;
  assign shamt = avs_writedata[dmae_pkg::CMD_SH +: 5];
  // Difference feeds both multiplier inputs
  assign diff  = opx_reg - opy_reg;
  // Positive amount shifts right, negative left
  assign shifted = (shamt[4]) ?
                   ({{8{data_reg[31]}}, data_reg} << {1'b0, 5'(-shamt)}) :
                   40'($signed({{8{data_reg[31]}}, data_reg}) >>> shamt);

  dmae_mult u_mult (
    .op_a         (mul_a),
    .op_b         (mul_b),
    .unsigned_sel (mul_uns),
    .int_sel      (mul_int),
    .prod_ext     (prod_ext),
    .prod_int     (prod_int)
  );

  always_comb begin
    mul_a    = opx_reg;
    mul_b    = opy_reg;
    mul_uns  = signedness_select;
    mul_int  = int_select;
    base     = acc_t;
    opnd     = prod_ext;
    sub      = 1'b0;
    pass     = 1'b1;
    store_en = 1'b0;
    case (op)
      dmae_pkg::OP_CLEAR: begin
        base     = '0;
        opnd     = '0;
        store_en = 1'b1;
      end
      dmae_pkg::OP_DSQ: begin
        mul_a = diff;
        mul_b = diff;
        base  = '0;
      end
      dmae_pkg::OP_DSQ_ACC: begin
        mul_a = diff;
        mul_b = diff;
      end
      dmae_pkg::OP_PROD_ACC: store_en = 1'b1;
      dmae_pkg::OP_PROD_SUB: begin
        sub      = 1'b1;
        store_en = 1'b1;
      end
      dmae_pkg::OP_SQ_ACC: mul_b = opx_reg;
      dmae_pkg::OP_PROD:   base = '0;
      dmae_pkg::OP_PROD_NEG: begin
        base = '0;
        sub  = 1'b1;
      end
      dmae_pkg::OP_SQUARE: begin
        mul_b = opx_reg;
        base  = '0;
      end
      dmae_pkg::OP_PF_STORE: begin
        pass     = 1'b0;
        store_en = 1'b1;
      end
      // Accumulator-only forms take no operand data
      dmae_pkg::OP_ACC_ADD: opnd = acc_n;
      dmae_pkg::OP_ACC_SUB: begin
        opnd = acc_n;
        sub  = 1'b1;
      end
      dmae_pkg::OP_ACC_NEG: begin
        base = '0;
        opnd = acc_t;
        sub  = 1'b1;
      end
      dmae_pkg::OP_ADD_DATA: opnd = shifted;
      dmae_pkg::OP_LOAD_ACC: begin
        base = '0;
        opnd = shifted;
      end
      // Shared multiplier, integer form
      dmae_pkg::OP_MCU_BYTE: begin
        mul_a   = {8'h00, opx_reg[7:0]};
        mul_b   = {8'h00, opy_reg[7:0]};
        mul_uns = 1'b1;
        mul_int = 1'b1;
        pass    = 1'b0;
      end
      dmae_pkg::OP_MCU_WORD: begin
        mul_int = 1'b1;
        pass    = 1'b0;
      end
      default: pass = 1'b0;
    endcase
  end

  // Complement plus carry one gives subtract with borrow low
  assign sum41 = {base[39], base} + ({opnd[39], opnd} ^ {41{sub}}) + {40'h0, sub};
  assign ov39  = sum41[40] ^ sum41[39];
  assign ov31  = flags_differ(sum41[40:31]);
  assign guard = flags_differ({sum41[39:32], sum41[39:38]});
  assign sat_en = tgt_b ? acc_b_clip_enable : acc_a_clip_enable;

  always_comb begin
    result    = sum41[39:0];
    clip_set  = ov39;
    guard_new = guard;
    if (sat_en && clip_width_select) begin
      if (ov39) begin
        result = sum41[40] ? dmae_pkg::SAT40_NEG : dmae_pkg::SAT40_POS;
      end
    end else if (sat_en) begin
      clip_set  = ov31;
      guard_new = 1'b0;
      if (ov31) begin
        result = sum41[40] ? dmae_pkg::SAT32_NEG : dmae_pkg::SAT32_POS;
      end
    end
  end

  // Guard trap, and catastrophic trap only with saturation off
  assign trap_fire = exec && pass &&
                     ((guard_new && trap_control_reg[tgt_b ? dmae_pkg::TC_OVB
                                                           : dmae_pkg::TC_OVA]) ||
                      (!sat_en && clip_set && trap_control_reg[dmae_pkg::TC_COV]));

  // ==========================================
  // Accumulators and flags
  logic sta_wr;
  logic clr_a;
  logic clr_b;
  assign sta_wr = wr_take && (avs_address == dmae_pkg::OFF_STATUS) && avs_byteenable[0];
  assign clr_a  = sta_wr && (avs_writedata[dmae_pkg::ST_SA] || avs_writedata[dmae_pkg::ST_SAB]);
  assign clr_b  = sta_wr && (avs_writedata[dmae_pkg::ST_SB] || avs_writedata[dmae_pkg::ST_SAB]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_a_reg       <= dmae_pkg::ACC_RST;
      acc_b_reg       <= dmae_pkg::ACC_RST;
      acc_a_guard_ovf <= 1'b0;
      acc_b_guard_ovf <= 1'b0;
    end else if (exec && pass) begin
      if (tgt_b) begin
        acc_b_reg       <= result;
        acc_b_guard_ovf <= guard_new;
      end else begin
        acc_a_reg       <= result;
        acc_a_guard_ovf <= guard_new;
      end
    end
  end

  // Set beats a same-cycle software clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_a_clip_sticky <= 1'b0;
      acc_b_clip_sticky <= 1'b0;
    end else begin
      acc_a_clip_sticky <= (exec && pass && !tgt_b && clip_set) || (acc_a_clip_sticky && !clr_a);
      acc_b_clip_sticky <= (exec && pass && tgt_b && clip_set) || (acc_b_clip_sticky && !clr_b);
    end
  end

  // Write-back of the other accumulator, which keeps its value, and the integer product
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      store_reg <= '0;
      mcu_reg   <= '0;
    end else if (exec) begin
      if (store_en) begin
        store_reg <= store_word(acc_n, avs_writedata[dmae_pkg::CMD_RND],
                                round_mode_select, store_clip_enable);
      end
      if (op == dmae_pkg::OP_MCU_BYTE) begin
        mcu_reg <= {16'h0000, prod_int[15:0]};
      end else if (op == dmae_pkg::OP_MCU_WORD) begin
        mcu_reg <= prod_int;
      end
    end
  end

  // ==========================================
  // Software-written registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      core_control_reg <= dmae_pkg::CORE_RST;
      opx_reg          <= '0;
      opy_reg          <= '0;
      data_reg         <= '0;
    end else if (wr_take) begin
      case (avs_address)
        dmae_pkg::OFF_CORE: core_control_reg <= 16'(be_merge({16'h0, core_control_reg},
                              avs_writedata, avs_byteenable) & {16'h0, dmae_pkg::CORE_MASK});
        dmae_pkg::OFF_OPX:  opx_reg  <= 16'(be_merge({16'h0, opx_reg}, avs_writedata,
                                                     avs_byteenable));
        dmae_pkg::OFF_OPY:  opy_reg  <= 16'(be_merge({16'h0, opy_reg}, avs_writedata,
                                                     avs_byteenable));
        dmae_pkg::OFF_DATA: data_reg <= be_merge(data_reg, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // Trap seen bit is write-one-to-clear; a new trap wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trap_control_reg <= dmae_pkg::TRAP_RST;
      trap_reg         <= 1'b0;
    end else begin
      trap_reg <= trap_fire;
      if (wr_take && (avs_address == dmae_pkg::OFF_TRAP) && avs_byteenable[0]) begin
        trap_control_reg[2:0] <= avs_writedata[2:0];
        trap_control_reg[dmae_pkg::TC_SEEN] <= trap_fire ||
          (trap_control_reg[dmae_pkg::TC_SEEN] && !avs_writedata[dmae_pkg::TC_SEEN]);
      end else if (trap_fire) begin
        trap_control_reg[dmae_pkg::TC_SEEN] <= 1'b1;
      end
    end
  end

  // ==========================================
  // Read path, latched on the request's first cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= '0;
    end else if (avs_read && wait_reg) begin
      case (avs_address)
        dmae_pkg::OFF_CORE:   readdata_reg <= {16'h0, core_control_reg};
        dmae_pkg::OFF_TRAP:   readdata_reg <= {28'h0, trap_control_reg};
        dmae_pkg::OFF_STATUS: readdata_reg <= {26'h0, either_acc_clip, either_acc_guard_ovf,
                                acc_b_clip_sticky, acc_a_clip_sticky,
                                acc_b_guard_ovf, acc_a_guard_ovf};
        dmae_pkg::OFF_OPX:    readdata_reg <= {16'h0, opx_reg};
        dmae_pkg::OFF_OPY:    readdata_reg <= {16'h0, opy_reg};
        dmae_pkg::OFF_DATA:   readdata_reg <= data_reg;
        dmae_pkg::OFF_ACCA_L: readdata_reg <= acc_a_reg[31:0];
        dmae_pkg::OFF_ACCA_H: readdata_reg <= {24'h0, acc_a_reg[39:32]};
        dmae_pkg::OFF_ACCB_L: readdata_reg <= acc_b_reg[31:0];
        dmae_pkg::OFF_ACCB_H: readdata_reg <= {24'h0, acc_b_reg[39:32]};
        dmae_pkg::OFF_STORE:  readdata_reg <= {16'h0, store_reg};
        dmae_pkg::OFF_MCU:    readdata_reg <= mcu_reg;
        default:              readdata_reg <= '0;
      endcase
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign arith_trap      = trap_reg;

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_narrow_no_guard: assert property (exec && pass && !tgt_b && acc_a_clip_enable &&
    !clip_width_select |=> !acc_a_guard_ovf && (!either_acc_guard_ovf || acc_b_guard_ovf))
    else $error("guard flag set in narrow clip mode");
  a_combined_bits: assert property (avs_read && !wait_reg && avs_address == dmae_pkg::OFF_STATUS
    |-> avs_readdata[4] == (avs_readdata[0] | avs_readdata[1]) &&
        avs_readdata[5] == (avs_readdata[2] | avs_readdata[3]))
    else $error("combined status bits wrong");
  a_clip_hold: assert property (acc_a_clip_sticky && !clr_a |=> acc_a_clip_sticky)
    else $error("clip flag dropped without clear");
  a_super_clamp: assert property (exec && pass && !tgt_b && acc_a_clip_enable &&
    clip_width_select && ov39 |=> acc_a_reg == dmae_pkg::SAT40_POS ||
                                  acc_a_reg == dmae_pkg::SAT40_NEG)
    else $error("wide clamp value wrong");
  a_guard_trap: assert property (exec && pass && guard_new &&
    trap_control_reg[tgt_b ? dmae_pkg::TC_OVB : dmae_pkg::TC_OVA] |=> arith_trap ##1 !arith_trap
    || trap_fire)
    else $error("guard trap missing");
  a_wrap_free: assert property (exec && pass && !tgt_b && !acc_a_clip_enable
    |=> acc_a_reg == $past(sum41[39:0]) && (acc_a_clip_sticky || !$past(ov39)))
    else $error("wrap or clip flag wrong");
  a_bus_one_wait: assert property ((avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("bus wait not one cycle");
  a_round_half: assert property (exec && store_en && avs_writedata[dmae_pkg::CMD_RND] &&
    !store_clip_enable && acc_n[15:0] == dmae_pkg::RND_HALF && !round_mode_select && !acc_n[16]
    |=> store_reg == $past(acc_n[31:16]))
    else $error("convergent rounding wrong");
endmodule

// ---- dv/dmae_host.sv ----
// Purpose: Bus master standing in for the instruction decoder
// Assumes: One access at a time, slave answers via waitrequest
// Notes:   Request held until waitrequest is sampled low
module dmae_host (
  // Clock
  input  wire logic        core_clk,
  // Avalon-MM master
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // ==========================================
  // Idle edge first, so no signal is set twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the accumulator engine
// Assumes: Reads complete one cycle after being taken
// Notes:   A monitor checks read data against a queue
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic       [7:0]  avs_address;
  logic              avs_read, avs_write, avs_waitrequest, arith_trap;
  logic       [31:0] avs_writedata, avs_readdata;
  logic       [31:0] exp_q[$], msk_q[$], dv;
  int                mismatches = 0, num_checks = 0, traps = 0;
  logic       [15:0] x, y, d;
  logic       [39:0] p, e, q, r, b;
  localparam dmae_pkg::dmae_op_e OPS_T [7] = '{dmae_pkg::OP_PROD_ACC, dmae_pkg::OP_SQ_ACC,
    dmae_pkg::OP_DSQ_ACC, dmae_pkg::OP_PROD_SUB, dmae_pkg::OP_PROD_NEG, dmae_pkg::OP_SQUARE,
    dmae_pkg::OP_DSQ};
  localparam logic [15:0] CORE_T [3] = '{16'h00b0, 16'h0000, 16'h0080};
  localparam logic [39:0] ACC_T [3] = '{40'h7fffffffff, 40'hfffffffe00, 40'h007fffffff};
  localparam logic [5:0]  MSK_T [3] = '{6'h2c, 6'h3f, 6'h3f};
  localparam int          TRP_T [3] = '{0, 2, 0};
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  dmae_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest));
  dmae_engine uut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .arith_trap(arith_trap));
  // ==========================================
  // Checking and bus helpers
  task automatic check(input string n, input logic [39:0] s, input logic [39:0] ex);
    num_checks++;
    if (s !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, ex, s);
    end
  endtask
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest) begin
      check("readdata", {8'h0, avs_readdata & msk_q.pop_front()}, {8'h0, exp_q.pop_front()});
    end
    if (arith_trap === 1'b1) begin
      traps++;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m = '1);
    exp_q.push_back(ex & m);
    msk_q.push_back(m);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic rd_acc(input logic [39:0] ex, input logic [7:0] lo = dmae_pkg::OFF_ACCA_L);
    rd(lo, ex[31:0]);
    rd(lo + 8'h4, {24'h0, ex[39:32]});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h669b));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(dmae_pkg::OFF_CORE, {16'h0, dmae_pkg::CORE_RST});
    rd(dmae_pkg::OFF_STATUS, 32'h0);
    rd_acc(dmae_pkg::ACC_RST);
    rd_acc(dmae_pkg::ACC_RST, dmae_pkg::OFF_ACCB_L);
    rd(8'hfc, 32'h0);
    $display("test reset done");
    // Signed int, unsigned int, then signed fractional
    for (int i = 0; i < 3; i++) begin
      x = 16'($urandom());
      y = 16'($urandom());
      wr(dmae_pkg::OFF_CORE, (i == 0) ? 32'h1 : (i == 1) ? 32'h1001 : 32'h0);
      wr(dmae_pkg::OFF_OPX, {16'h0, x});
      wr(dmae_pkg::OFF_OPY, {16'h0, y});
      p = (i == 1) ? {24'h0, x} * {24'h0, y} : {{24{x[15]}}, x} * {{24{y[15]}}, y};
      e = (i == 2) ? p << 1 : p;
      wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_PROD});
      rd_acc(e);
      wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_MCU_WORD});
      rd(dmae_pkg::OFF_MCU, p[31:0]);
    end
    wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_MCU_BYTE});
    rd(dmae_pkg::OFF_MCU, {24'h0, x[7:0]} * {24'h0, y[7:0]});
    $display("test multiply done");
    // Wide clamp, wrap with traps, narrow clamp
    for (int i = 0; i < 3; i++) begin
      wr(dmae_pkg::OFF_CORE, {16'h0, CORE_T[i]});
      wr(dmae_pkg::OFF_STATUS, 32'h24);
      wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_CLEAR});
      wr(dmae_pkg::OFF_TRAP, (i > 0) ? 32'h5 : 32'h0);
      wr(dmae_pkg::OFF_DATA, 32'h7fffffff);
      traps = 0;
      repeat (2) wr(dmae_pkg::OFF_CMD, {19'h0, 5'h18, 3'h0, dmae_pkg::OP_ADD_DATA});
      rd_acc(ACC_T[i]);
      rd(dmae_pkg::OFF_STATUS, 32'h24, {26'h0, MSK_T[i]});
      check("trap_count", 40'(traps), 40'(TRP_T[i]));
      if (i == 0) begin
        wr(dmae_pkg::OFF_CMD, {19'h0, 5'h0, 3'h3, dmae_pkg::OP_PF_STORE});
        rd(dmae_pkg::OFF_STORE, {16'h0, dmae_pkg::ST_POS});
      end
    end
    $display("test saturation done");
    // Remaining opcodes in signed integer mode, sums kept clear of overflow
    wr(dmae_pkg::OFF_CORE, 32'h1);
    d = x - y;
    p = {{24{x[15]}}, x} * {{24{y[15]}}, y};
    q = {{24{x[15]}}, x} * {{24{x[15]}}, x};
    r = {{24{d[15]}}, d} * {{24{d[15]}}, d};
    wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_CLEAR});
    for (int i = 0; i < 7; i++) begin
      wr(dmae_pkg::OFF_CMD, {27'h0, OPS_T[i]});
      if (i > 2) begin
        rd_acc((i == 3) ? q + r : (i == 4) ? -p : (i == 5) ? q : r);
      end
    end
    dv = $urandom();
    b = {{12{dv[31]}}, dv[31:4]};
    wr(dmae_pkg::OFF_DATA, dv);
    wr(dmae_pkg::OFF_CMD, {19'h0, 5'h04, 3'h1, dmae_pkg::OP_LOAD_ACC});
    wr(dmae_pkg::OFF_CMD, {27'h1, dmae_pkg::OP_ACC_ADD});
    rd_acc(b + r, dmae_pkg::OFF_ACCB_L);
    wr(dmae_pkg::OFF_CMD, {27'h1, dmae_pkg::OP_ACC_SUB});
    wr(dmae_pkg::OFF_CMD, {27'h1, dmae_pkg::OP_ACC_NEG});
    rd_acc(-b, dmae_pkg::OFF_ACCB_L);
    // Low word exactly one half: convergent keeps, conventional rounds up
    wr(dmae_pkg::OFF_DATA, 32'h00028000);
    wr(dmae_pkg::OFF_CMD, {27'h0, dmae_pkg::OP_LOAD_ACC});
    for (int i = 0; i < 2; i++) begin
      wr(dmae_pkg::OFF_CORE, 32'h1 + 32'(2 * i));
      wr(dmae_pkg::OFF_CMD, {19'h0, 5'h0, 3'h3, dmae_pkg::OP_PF_STORE});
      rd(dmae_pkg::OFF_STORE, 32'h2 + 32'(i));
    end
    $display("test opcodes done");
    print_verdict();
  end
endmodule
